// File: rtl/ccc_config_chains.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Reset-loaded chain spans 367 positions, 304 of them carry configuration.
// - After self test, 367 boot ROM bits shift in, most significant first.
// - Unused positions fall out the far end; only used bits are held.
// - 36-bit write-many chain takes six bits per retired data port write.
// - 60-bit error chain loses six bits per trigger write, destructively.
// - Data port write stages six bits; shifted in only at retire.
// - After a trigger, data port read returns the six bits moved there.
// - Writing one to trigger bit 0 moves six error bits to data port.
// - Multibit fields MSB to LSB; field LSB sits first in chain.
// - Decoded eight-bit victim threshold; streaming only at counts whose bit is set, max six.
// - System bus ratio one-hot: 1.5X, 2.0X, 2.5X, 3.0X.
// - Cache write data delay in cache clocks; index delay in core clocks.
// - Programmed idle gaps between cache transactions of each pairing.
// - Frame-align bit starts cache transactions on A-phase rising edges.
// - System forwarded clock delayed 0 to 2 phases by two-bit field.
// - Cache forwarded clock delay codes give 0, 0, 1, 2 phases.
// - Forwarded clock edges enabled from the first clock after reset; presets seed receive unload pointers.
// - Enables gate speculative refs, store-conditional pins, off-chip barriers.
// - Limits on outstanding acknowledgements (5 bits) and victims (3 bits).
module ccc_config_chains import ccc_pkg::*; #(
    parameter int RLC_BITS = RLC_LEN
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic BUILT_IN_SELF_TEST_DONE_IN,
    input wire logic ROM_BIT_IN,
    input wire logic ROM_VALID_IN,
    input wire logic PRIV_WR_IN,
    input wire logic PRIV_RD_IN,
    input wire logic [1:0] PRIV_SEL_IN,
    input wire logic [63:0] PRIV_WDATA_IN,
    input wire logic RETIRE_IN,
    input wire logic ERR_LOAD_IN,
    input wire logic [ERC_LEN-1:0] ERR_DATA_IN,
    input wire logic [3:0] VICTIM_COUNT_IN,
    output logic ROM_REQ_OUT,
    output logic LOAD_DONE_OUT,
    output logic [63:0] PRIV_RDATA_OUT,
    output logic [WMC_LEN-1:0] MANY_CHAIN_OUT,
    output logic [RLC_USED-1:0] ONCE_CHAIN_OUT,
    output logic VICTIM_STREAM_OUT,
    output logic [3:0] SYS_RATIO_OUT,
    output logic [2:0] SYS_RATIO_IDX_OUT,
    output logic PROBE_STALL_OUT,
    output logic [2:0] LATE_WRITE_CACHE_OUT,
    output logic [1:0] LATE_WRITE_CORE_OUT,
    output logic WR_WR_GAP_OUT,
    output logic [5:0] RD_WR_GAP_OUT,
    output logic RD_RD_GAP_OUT,
    output logic [3:0] WR_RD_GAP_OUT,
    output logic FRAME_ALIGN_OUT,
    output logic [1:0] SYS_FWD_PHASES_OUT,
    output logic [1:0] CACHE_FWD_PHASES_OUT,
    output logic FWD_RISE_EN_OUT,
    output logic FWD_FALL_EN_OUT,
    output logic [1:0] SYS_RX_PTR_OUT,
    output logic [1:0] CACHE_RX_PTR_OUT,
    output logic SPEC_REF_EN_OUT,
    output logic STORE_COND_EN_OUT,
    output logic BARRIER_EN_OUT,
    output logic [4:0] ACK_LIMIT_OUT,
    output logic [2:0] VIC_LIMIT_OUT
);
    ccc_state_t state;
    logic [8:0] bit_cnt;
    logic [RLC_USED-1:0] once_chain;
    logic [WMC_LEN-1:0] many_chain;
    logic [ERC_LEN-1:0] err_chain;
    logic [PORT_W-1:0] stage;
    logic stage_full;
    logic [PORT_W-1:0] port_data;
    logic wr_data;
    logic wr_trig;
    logic [7:0] thresh;
    logic [2:0] wc_idx;
    logic stream_hit;

    assign wr_data = PRIV_WR_IN && (PRIV_SEL_IN == SEL_DATA_PORT);
    assign wr_trig = PRIV_WR_IN && (PRIV_SEL_IN == SEL_SHIFT_TRIG) && PRIV_WDATA_IN[TRIG_BIT];

    // Boot ROM load sequencer
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= CCC_IDLE;
            bit_cnt <= 9'h000;
        end else begin
            unique case (state)
                CCC_IDLE: begin
                    if (BUILT_IN_SELF_TEST_DONE_IN) begin
                        state <= CCC_LOAD;
                    end
                end
                CCC_LOAD: begin
                    if (ROM_VALID_IN) begin
                        if (bit_cnt == 9'(RLC_BITS - 1)) begin
                            state <= CCC_DONE;
                        end
                        bit_cnt <= bit_cnt + 9'h001;
                    end
                end
                CCC_DONE: begin
                    state <= CCC_DONE;
                end
            endcase
        end
    end

    // Reset-loaded chain: bits enter at the top and move toward index 0,
    // so early surplus bits are pushed out of the low end
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            once_chain <= '0;
        end else if (state == CCC_LOAD && ROM_VALID_IN) begin
            once_chain <= {ROM_BIT_IN, once_chain[RLC_USED-1:1]};
        end
    end

    // Software staging and write-many chain
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            stage <= 6'h00;
            stage_full <= 1'b0;
            many_chain <= '0;
        end else begin
            if (stage_full && RETIRE_IN) begin
                many_chain <= {stage, many_chain[WMC_LEN-1:PORT_W]};
            end
            if (wr_data) begin
                stage <= PRIV_WDATA_IN[PORT_W-1:0];
                stage_full <= 1'b1;
            end else if (RETIRE_IN) begin
                stage_full <= 1'b0;
            end
        end
    end

    // Error chain, destructive readout
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            err_chain <= '0;
            port_data <= 6'h00;
        end else if (wr_trig) begin
            port_data <= err_chain[PORT_W-1:0];
            err_chain <= {6'h00, err_chain[ERC_LEN-1:PORT_W]};
        end else if (ERR_LOAD_IN) begin
            err_chain <= ERR_DATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRIV_RDATA_OUT <= 64'h0;
        end else if (PRIV_RD_IN && PRIV_SEL_IN == SEL_DATA_PORT) begin
            PRIV_RDATA_OUT <= {58'h0, port_data};
        end else begin
            PRIV_RDATA_OUT <= 64'h0;
        end
    end

    assign thresh = once_chain[POS_VICTIM_THRESH +: 8];
    // One-hot ratio to index 0..3, 4 for an illegal code
    always_comb begin
        unique case (once_chain[POS_SYS_RATIO +: 4])
            RATIO_1P5: wc_idx = 3'h0;
            RATIO_2P0: wc_idx = 3'h1;
            RATIO_2P5: wc_idx = 3'h2;
            RATIO_3P0: wc_idx = 3'h3;
            default: wc_idx = 3'h4;
        endcase
    end

    // Decodes mirror the held chain; duplicated fields are the loader's concern
    // Decoded threshold: bit n set means stream at n+1 victims, for bits 0 to 5
    always_comb begin
        stream_hit = 1'b0;
        if (VICTIM_COUNT_IN != 4'h0 && VICTIM_COUNT_IN <= 4'h6) begin
            stream_hit = thresh[3'(VICTIM_COUNT_IN - 4'h1)];
        end
    end

    // Load status toward the boot ROM
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ROM_REQ_OUT <= 1'b0;
            LOAD_DONE_OUT <= 1'b0;
        end else begin
            // Drop the request on the last bit so no extra bit is pulled
            ROM_REQ_OUT <= (state == CCC_LOAD)
                && !(ROM_VALID_IN && bit_cnt == 9'(RLC_BITS - 1));
            LOAD_DONE_OUT <= (state == CCC_DONE);
        end
    end

    // Chain images
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            MANY_CHAIN_OUT <= '0;
            ONCE_CHAIN_OUT <= '0;
        end else begin
            MANY_CHAIN_OUT <= many_chain;
            // Held chain only moves during the load
            ONCE_CHAIN_OUT <= once_chain;
        end
    end

    // Victim streaming, only once the configuration is loaded
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            VICTIM_STREAM_OUT <= 1'b0;
        end else begin
            VICTIM_STREAM_OUT <= (state == CCC_DONE) && stream_hit;
        end
    end

    // System bus ratio, raw and as an index
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SYS_RATIO_OUT <= 4'h0;
            SYS_RATIO_IDX_OUT <= 3'h0;
        end else begin
            SYS_RATIO_OUT <= once_chain[POS_SYS_RATIO +: 4];
            SYS_RATIO_IDX_OUT <= wc_idx;
        end
    end

    // Cache write timing
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PROBE_STALL_OUT <= 1'b0;
            LATE_WRITE_CACHE_OUT <= 3'h0;
            LATE_WRITE_CORE_OUT <= 2'h0;
        end else begin
            // Counts are taken as loaded; the upper flag is set by the loader
            PROBE_STALL_OUT <= once_chain[POS_PROBE_STALL];
            LATE_WRITE_CACHE_OUT <= once_chain[POS_LW_CACHE +: 3];
            LATE_WRITE_CORE_OUT <= once_chain[POS_LW_CORE +: 2];
        end
    end

    // Idle gaps and transaction alignment
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            WR_WR_GAP_OUT <= 1'b0;
            RD_WR_GAP_OUT <= 6'h00;
            RD_RD_GAP_OUT <= 1'b0;
            WR_RD_GAP_OUT <= 4'h0;
            FRAME_ALIGN_OUT <= 1'b0;
        end else begin
            // Gap counts are in core clock cycles
            WR_WR_GAP_OUT <= once_chain[POS_WR_WR_GAP];
            RD_WR_GAP_OUT <= once_chain[POS_RD_WR_GAP +: 6];
            RD_RD_GAP_OUT <= once_chain[POS_RD_RD_GAP];
            WR_RD_GAP_OUT <= once_chain[POS_WR_RD_GAP +: 4];
            FRAME_ALIGN_OUT <= once_chain[POS_FRAME_ALIGN];
        end
    end

    // Forwarded clock controls
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SYS_FWD_PHASES_OUT <= 2'h0;
            CACHE_FWD_PHASES_OUT <= 2'h0;
            FWD_RISE_EN_OUT <= 1'b0;
            FWD_FALL_EN_OUT <= 1'b0;
            SYS_RX_PTR_OUT <= 2'h0;
            CACHE_RX_PTR_OUT <= 2'h0;
        end else begin
            // Code 3 clamps to the two-phase maximum
            SYS_FWD_PHASES_OUT <= (once_chain[POS_SYS_FWD_DLY +: 2] == 2'h3) ? 2'h2
                : once_chain[POS_SYS_FWD_DLY +: 2];
            CACHE_FWD_PHASES_OUT <= (once_chain[POS_CACHE_FWD_DLY +: 2] == 2'h0) ? 2'h0
                : 2'(once_chain[POS_CACHE_FWD_DLY +: 2] - 2'h1);
            FWD_RISE_EN_OUT <= 1'b1;
            FWD_FALL_EN_OUT <= 1'b1;
            SYS_RX_PTR_OUT <= once_chain[POS_SYS_RX_PRESET +: 2];
            CACHE_RX_PTR_OUT <= once_chain[POS_CACHE_RX_PRESET +: 2];
        end
    end

    // Enables and outstanding limits
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SPEC_REF_EN_OUT <= 1'b0;
            STORE_COND_EN_OUT <= 1'b0;
            BARRIER_EN_OUT <= 1'b0;
            ACK_LIMIT_OUT <= 5'h00;
            VIC_LIMIT_OUT <= 3'h0;
        end else begin
            SPEC_REF_EN_OUT <= once_chain[POS_SPEC_REF_EN];
            STORE_COND_EN_OUT <= once_chain[POS_STORE_COND_EN];
            BARRIER_EN_OUT <= once_chain[POS_BARRIER_EN];
            ACK_LIMIT_OUT <= once_chain[POS_ACK_LIMIT +: 5];
            VIC_LIMIT_OUT <= once_chain[POS_VIC_LIMIT +: 3];
        end
    end
endmodule : ccc_config_chains

// File: shared/ccc_pkg.sv
package ccc_pkg;
    // Chain geometry
    localparam int RLC_LEN = 367;
    localparam int RLC_USED = 304;
    localparam int WMC_LEN = 36;
    localparam int ERC_LEN = 60;
    localparam int PORT_W = 6;
    // Privileged register selects
    localparam logic [1:0] SEL_DATA_PORT = 2'h1;
    localparam logic [1:0] SEL_SHIFT_TRIG = 2'h2;
    localparam int TRIG_BIT = 0;
    // Field positions in the held reset-loaded chain (LSB index)
    localparam int POS_VICTIM_THRESH = 3;
    localparam int POS_BARRIER_EN = 25;
    localparam int POS_ACK_LIMIT = 26;
    localparam int POS_VIC_LIMIT = 31;
    localparam int POS_WR_WR_GAP = 35;
    localparam int POS_RD_WR_GAP = 36;
    localparam int POS_RD_RD_GAP = 42;
    localparam int POS_WR_RD_GAP = 44;
    localparam int POS_SPEC_REF_EN = 57;
    localparam int POS_PROBE_STALL = 60;
    localparam int POS_STORE_COND_EN = 118;
    localparam int POS_LW_CACHE = 119;
    localparam int POS_LW_CORE = 122;
    localparam int POS_FRAME_ALIGN = 127;
    localparam int POS_CACHE_FWD_DLY = 128;
    localparam int POS_CACHE_RX_PRESET = 136;
    localparam int POS_SYS_RX_PRESET = 142;
    localparam int POS_SYS_FWD_DLY = 144;
    localparam int POS_SYS_RATIO = 11;
    // System bus ratio one-hot codes
    localparam logic [3:0] RATIO_1P5 = 4'h1;
    localparam logic [3:0] RATIO_2P0 = 4'h2;
    localparam logic [3:0] RATIO_2P5 = 4'h4;
    localparam logic [3:0] RATIO_3P0 = 4'h8;
    typedef enum logic [2:0] {
        CCC_IDLE = 3'b001,
        CCC_LOAD = 3'b010,
        CCC_DONE = 3'b100
    } ccc_state_t;
endpackage : ccc_pkg

// File: tb/ccc_rom_model.sv
`timescale 1ns/1ns
module ccc_rom_model import ccc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [RLC_LEN-1:0] image_in,
    output logic bit_out,
    output logic valid_out
);
    int sent;
    // Idle line toggles so a stale bit never looks valid
    always @(negedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sent <= 0;
            valid_out <= 1'b0;
            bit_out <= 1'b0;
        end else if (req_in && sent < RLC_LEN) begin
            bit_out <= image_in[RLC_LEN-1-sent];
            valid_out <= 1'b1;
            sent <= sent + 1;
        end else begin
            bit_out <= ~bit_out;
            valid_out <= 1'b0;
        end
    end
endmodule : ccc_rom_model

// File: tb/ccc_config_chains_asserts.sv
`timescale 1ns/1ns
module ccc_chk import ccc_pkg::*; (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PRIV_RD_IN,
    input wire logic [1:0] PRIV_SEL_IN,
    input wire logic RETIRE_IN,
    input wire logic ROM_REQ_OUT,
    input wire logic LOAD_DONE_OUT,
    input wire logic [63:0] PRIV_RDATA_OUT,
    input wire logic [WMC_LEN-1:0] MANY_CHAIN_OUT,
    input wire logic [RLC_USED-1:0] ONCE_CHAIN_OUT,
    input wire logic VICTIM_STREAM_OUT,
    input wire logic [3:0] SYS_RATIO_OUT,
    input wire logic [2:0] SYS_RATIO_IDX_OUT,
    input wire logic [1:0] SYS_FWD_PHASES_OUT,
    input wire logic [1:0] CACHE_FWD_PHASES_OUT,
    input wire logic FWD_RISE_EN_OUT,
    input wire logic FWD_FALL_EN_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    sequence quiet_s;
        (!RETIRE_IN)[*3];
    endsequence
    done_hold_a: assert property (LOAD_DONE_OUT |=> LOAD_DONE_OUT) else $error("done fell");
    once_fix_a: assert property (LOAD_DONE_OUT |=> $stable(ONCE_CHAIN_OUT)) else $error("chain");
    req_off_a: assert property (LOAD_DONE_OUT |-> !ROM_REQ_OUT) else $error("rom req");
    rd_idle_a: assert property (!(PRIV_RD_IN && PRIV_SEL_IN == SEL_DATA_PORT)
        |=> PRIV_RDATA_OUT == 64'h0) else $error("read data");
    rd_upper_a: assert property (PRIV_RDATA_OUT[63:6] == 58'h0) else $error("upper");
    many_hold_a: assert property (quiet_s |-> $stable(MANY_CHAIN_OUT)) else $error("many");
    ratio_idx_a: assert property ($past(LOAD_DONE_OUT)
        |-> (SYS_RATIO_IDX_OUT == 3'h4) == !$onehot(SYS_RATIO_OUT)) else $error("ratio");
    fwd_en_a: assert property (LOAD_DONE_OUT |-> FWD_RISE_EN_OUT && FWD_FALL_EN_OUT)
        else $error("edge enables");
    fwd_dly_a: assert property (LOAD_DONE_OUT |-> SYS_FWD_PHASES_OUT != 2'h3
        && CACHE_FWD_PHASES_OUT != 2'h3) else $error("phases");
    vic_done_a: assert property (VICTIM_STREAM_OUT |-> LOAD_DONE_OUT) else $error("stream");
endmodule : ccc_chk
bind ccc_config_chains ccc_chk chk_i (.*);

// File: tb/ccc_config_chains_bench.sv
`timescale 1ns/1ns
module ccc_config_chains_bench import ccc_pkg::*;;
    logic MCLK_IN, RST_IN, BUILT_IN_SELF_TEST_DONE_IN, ROM_BIT_IN, ROM_VALID_IN, PRIV_WR_IN, PRIV_RD_IN;
    logic RETIRE_IN, ERR_LOAD_IN, ROM_REQ_OUT, LOAD_DONE_OUT, VICTIM_STREAM_OUT, PROBE_STALL_OUT;
    logic WR_WR_GAP_OUT, RD_RD_GAP_OUT, FRAME_ALIGN_OUT, FWD_RISE_EN_OUT, FWD_FALL_EN_OUT;
    logic SPEC_REF_EN_OUT, STORE_COND_EN_OUT, BARRIER_EN_OUT;
    logic [1:0] PRIV_SEL_IN, LATE_WRITE_CORE_OUT, SYS_FWD_PHASES_OUT, CACHE_FWD_PHASES_OUT;
    logic [1:0] SYS_RX_PTR_OUT, CACHE_RX_PTR_OUT;
    logic [63:0] PRIV_WDATA_IN, PRIV_RDATA_OUT, q;
    logic [ERC_LEN-1:0] ERR_DATA_IN, e;
    logic [3:0] VICTIM_COUNT_IN, SYS_RATIO_OUT, WR_RD_GAP_OUT;
    logic [2:0] SYS_RATIO_IDX_OUT, LATE_WRITE_CACHE_OUT, VIC_LIMIT_OUT;
    logic [5:0] RD_WR_GAP_OUT;
    logic [4:0] ACK_LIMIT_OUT;
    logic [WMC_LEN-1:0] MANY_CHAIN_OUT, exp_many;
    logic [RLC_USED-1:0] ONCE_CHAIN_OUT, exp_once;
    logic [RLC_LEN-1:0] img;
    int error_cnt, cmp_count, cycles;
    ccc_config_chains uut (.*);
    ccc_rom_model rom (.clk_in(MCLK_IN), .rst_in(RST_IN), .req_in(ROM_REQ_OUT), .image_in(img),
        .bit_out(ROM_BIT_IN), .valid_out(ROM_VALID_IN));
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK_IN);
    endtask : cyc
    task automatic chk(input logic [RLC_USED-1:0] got, input logic [RLC_USED-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] sel, input logic [63:0] d, input logic ret);
        PRIV_WR_IN = 1'b1;
        PRIV_SEL_IN = sel;
        PRIV_WDATA_IN = d;
        cyc(1);
        PRIV_WR_IN = 1'b0;
        RETIRE_IN = ret;
        cyc(1);
        RETIRE_IN = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd();
        PRIV_RD_IN = 1'b1;
        PRIV_SEL_IN = SEL_DATA_PORT;
        cyc(1);
        PRIV_RD_IN = 1'b0;
        q = PRIV_RDATA_OUT;
    endtask : rd
    task automatic boot();
        int n;
        RST_IN = 1'b1;
        cyc(10);
        RST_IN = 1'b0;
        cyc(2);
        BUILT_IN_SELF_TEST_DONE_IN = 1'b1;
        for (n = 0; n < 500 && LOAD_DONE_OUT !== 1'b1; n++) cyc(1);
        BUILT_IN_SELF_TEST_DONE_IN = 1'b0;
        cyc(2);
    endtask : boot
    function automatic void put(int pos, int w, logic [7:0] v);
        for (int i = 0; i < w; i++) img[RLC_USED-1-pos-i] = v[i];
    endfunction : put
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        MCLK_IN = 1'b0;
        forever #5 MCLK_IN = ~MCLK_IN;
    end
    always @(posedge MCLK_IN) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {RST_IN, BUILT_IN_SELF_TEST_DONE_IN, PRIV_WR_IN, PRIV_RD_IN, RETIRE_IN, ERR_LOAD_IN} = 6'h20;
        {PRIV_SEL_IN, PRIV_WDATA_IN, ERR_DATA_IN, VICTIM_COUNT_IN} = '0;
        img = '0;
        for (int k = 0; k < 4; k++) begin
            // Unused lead bits all ones; duplicates left equal at zero
            img = {{63{1'b1}}, {RLC_USED{1'b0}}};
            put(POS_SYS_RATIO, 4, 8'h1 << k);
            put(POS_SYS_FWD_DLY, 2, 8'(k));
            put(POS_CACHE_FWD_DLY, 2, 8'(k));
            put(POS_ACK_LIMIT, 5, 8'(7 * k + 1));
            put(POS_VIC_LIMIT, 3, 8'(k + 3));
            put(POS_VICTIM_THRESH, 8, 8'h05);
            // Stall set as if the cache ratio sat in the 4.0X to 8.0X range
            put(POS_PROBE_STALL, 1, 8'(k % 2));
            // Cache count up to 3 with core count 1 keeps the upper flag clear
            put(POS_LW_CACHE, 3, 8'(k));
            put(POS_LW_CORE, 2, 8'h01);
            put(POS_WR_WR_GAP, 1, 8'(k / 2));
            put(POS_RD_WR_GAP, 6, 8'(9 * k + 17));
            put(POS_RD_RD_GAP, 1, 8'(k % 2));
            put(POS_WR_RD_GAP, 4, 8'(3 * k + 4));
            put(POS_FRAME_ALIGN, 1, 8'(k / 2));
            put(POS_SYS_RX_PRESET, 2, 8'(3 - k));
            put(POS_CACHE_RX_PRESET, 2, 8'(k));
            put(POS_SPEC_REF_EN, 1, 8'(k % 2));
            put(POS_STORE_COND_EN, 1, 8'(k / 2));
            put(POS_BARRIER_EN, 1, 8'((k + 1) % 2));
            for (int j = 0; j < RLC_USED; j++) exp_once[j] = img[RLC_USED-1-j];
            VICTIM_COUNT_IN = 4'(k + 1);
            boot();
            chk(ONCE_CHAIN_OUT, exp_once);
            chk({LOAD_DONE_OUT, ROM_REQ_OUT}, 2'h2);
            chk(SYS_RATIO_OUT, 1 << k);
            chk(SYS_RATIO_IDX_OUT, k);
            chk(SYS_FWD_PHASES_OUT, k - (k == 3));
            chk(CACHE_FWD_PHASES_OUT, k - (k > 0));
            chk({ACK_LIMIT_OUT, VIC_LIMIT_OUT}, ((7 * k + 1) << 3) + k + 3);
            chk(VICTIM_STREAM_OUT, k % 2 == 0);
            chk(PROBE_STALL_OUT, k % 2);
            chk({LATE_WRITE_CACHE_OUT, LATE_WRITE_CORE_OUT}, 4 * k + 1);
            chk({WR_WR_GAP_OUT, RD_RD_GAP_OUT}, {1'(k / 2), 1'(k % 2)});
            chk({RD_WR_GAP_OUT, WR_RD_GAP_OUT}, {6'(9 * k + 17), 4'(3 * k + 4)});
            chk(FRAME_ALIGN_OUT, k / 2);
            chk({SYS_RX_PTR_OUT, CACHE_RX_PTR_OUT}, {2'(3 - k), 2'(k)});
            chk({SPEC_REF_EN_OUT, STORE_COND_EN_OUT}, {1'(k % 2), 1'(k / 2)});
            chk(BARRIER_EN_OUT, (k + 1) % 2);
            chk({FWD_RISE_EN_OUT, FWD_FALL_EN_OUT}, 2'h3);
            $display("test boot %0d done", k);
        end
        wr(SEL_DATA_PORT, 64'hffc0_0015, 1'b0);
        chk(MANY_CHAIN_OUT, 0);
        RETIRE_IN = 1'b1;
        cyc(1);
        RETIRE_IN = 1'b0;
        cyc(2);
        exp_many = {6'h15, 30'h0};
        chk(MANY_CHAIN_OUT, exp_many);
        for (int i = 0; i < 5; i++) begin
            wr(SEL_DATA_PORT, 64'hffc0 | (i * 9 + 5), 1'b1);
            exp_many = {6'(i * 9 + 5), exp_many[35:6]};
            chk(MANY_CHAIN_OUT, exp_many);
        end
        chk(ONCE_CHAIN_OUT, exp_once);
        $display("test data port done");
        ERR_DATA_IN = 60'hfedcba987654321;
        e = ERR_DATA_IN;
        ERR_LOAD_IN = 1'b1;
        cyc(1);
        ERR_LOAD_IN = 1'b0;
        wr(SEL_SHIFT_TRIG, 64'hfffe, 1'b0);
        rd();
        chk(q, 0);
        for (int i = 0; i < 11; i++) begin
            wr(SEL_SHIFT_TRIG, 64'h1, 1'b0);
            rd();
            chk(q, e[5:0]);
            e = e >> 6;
        end
        $display("test error chain done");
        close_out();
    end
endmodule : ccc_config_chains_bench
